// file: mgtx_pkg.sv
package mgtx_pkg;

	// Control bus addresses; only the address byte of a reset is sent.
	localparam logic [7:0] ADDR_GEN_RESET = 8'h01;
	localparam logic [7:0] ADDR_GEN_CTRL = 8'he0;
	localparam logic [7:0] ADDR_TX_MODE = 8'he1;

	localparam int unsigned REG_W = 16;
	localparam int unsigned CNT_W = 5;
	localparam logic [4:0] ADDR_LAST = 5'h07;
	localparam logic [4:0] DATA_LAST = 5'h0f;

	localparam logic [15:0] GEN_CTRL_RST_VAL = 16'h0000;
	localparam logic [15:0] TX_MODE_RST_VAL = 16'h0000;

	// General control field positions.
	localparam int unsigned GC_POS_OFF = 14;
	localparam int unsigned GC_INV_OFF = 13;
	localparam int unsigned GC_XTAL = 12;
	localparam int unsigned GC_LOOP = 11;
	localparam int unsigned GC_EQ_DIS = 10;
	localparam int unsigned GC_RELAY = 9;
	localparam int unsigned GC_PWR = 8;
	localparam int unsigned GC_RST = 7;
	localparam int unsigned GC_IRQ_EN = 6;
	localparam int unsigned GC_MASK_HI = 5;

	// Transmit mode field positions.
	localparam int unsigned TM_MODE_HI = 14;
	localparam int unsigned TM_MODE_LO = 12;
	localparam int unsigned TM_LVL_HI = 11;
	localparam int unsigned TM_LVL_LO = 9;
	localparam int unsigned TM_TW_HI = 7;
	localparam int unsigned TM_TW_LO = 5;
	localparam int unsigned TM_FMT_HI = 4;
	localparam int unsigned TM_FMT_LO = 3;
	localparam int unsigned TM_LEN_HI = 2;

	typedef enum logic [2:0] {
		TXM_OFF = 3'h0, TXM_TONES = 3'h1, TXM_B202_150 = 3'h2, TXM_B202_1200 = 3'h3,
		TXM_V23_75 = 3'h4, TXM_V23_1200 = 3'h5, TXM_B103_LO = 3'h6, TXM_B103_HI = 3'h7
	} mgtx_tx_mode_type;

	typedef enum logic [1:0] {
		FMT_ODD = 2'h0, FMT_EVEN = 2'h1, FMT_NOPAR = 2'h2, FMT_SYNC = 2'h3
	} mgtx_fmt_type;

	typedef enum logic [1:0] {
		SRC_BUFFER = 2'h0, SRC_ONES = 2'h1, SRC_ZEROS = 2'h2, SRC_ALT = 2'h3
	} mgtx_src_type;

	typedef enum {BUS_ADDR, BUS_DATA, BUS_SKIP} mgtx_bus_state_type;

endpackage

// file: mgtx_wr_if.sv
`timescale 1ns/1ps
interface mgtx_wr_if;
	logic wr_stb;
	logic [7:0] wr_addr;
	logic [15:0] wr_data;
	logic greset_stb;
	modport src (output wr_stb, output wr_addr, output wr_data, output greset_stb);
	modport dst (input wr_stb, input wr_addr, input wr_data, input greset_stb);
endinterface

// file: mgtx_cbus_rx.sv
`timescale 1ns/1ps
module mgtx_cbus_rx #(
	parameter int unsigned DATA_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic csn_n_i,
	input wire logic sclk_i,
	input wire logic cmd_data_i,
	mgtx_wr_if.src wr
);
	import mgtx_pkg::*;

	generate if (DATA_W != REG_W) begin : g_chk
		$error("Only 16-bit control words are supported.");
	end endgenerate

	mgtx_bus_state_type state_r;
	logic sclk_d_r;
	logic [CNT_W-1:0] cnt_r;
	logic [15:0] shift_r;
	logic rise;
	logic [15:0] shift_nxt;
	logic addr_done;
	logic data_done;

	assign rise = sclk_i & ~sclk_d_r & ~csn_n_i;
	assign shift_nxt = {shift_r[14:0], cmd_data_i};
	assign addr_done = rise && (state_r == BUS_ADDR) && (cnt_r == ADDR_LAST);
	assign data_done = rise && (state_r == BUS_DATA) && (cnt_r == DATA_LAST);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_d_r <= 1'b0;
		end else begin
			sclk_d_r <= sclk_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_r <= 16'h0000;
		end else if (rise) begin
			shift_r <= shift_nxt;
		end
	end

	// A frame restarts whenever select goes high, so a cut frame commits nothing.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= BUS_ADDR;
			cnt_r <= '0;
		end else if (csn_n_i) begin
			state_r <= BUS_ADDR;
			cnt_r <= '0;
		end else if (rise) begin
			case (state_r)
				BUS_ADDR: begin
					cnt_r <= addr_done ? '0 : cnt_r + 5'h01;
					if (addr_done) begin
						if (shift_nxt[7:0] == ADDR_GEN_CTRL || shift_nxt[7:0] == ADDR_TX_MODE) begin
							state_r <= BUS_DATA;
						end else begin
							state_r <= BUS_SKIP;
						end
					end
				end
				BUS_DATA: begin
					cnt_r <= cnt_r + 5'h01;
					if (data_done) begin
						state_r <= BUS_SKIP;
					end
				end
				default: begin
					cnt_r <= cnt_r;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr.wr_addr <= 8'h00;
		end else if (addr_done) begin
			wr.wr_addr <= shift_nxt[7:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr.wr_stb <= 1'b0;
			wr.wr_data <= 16'h0000;
			wr.greset_stb <= 1'b0;
		end else begin
			wr.wr_stb <= data_done;
			wr.wr_data <= data_done ? shift_nxt : wr.wr_data;
			wr.greset_stb <= addr_done && (shift_nxt[7:0] == ADDR_GEN_RESET);
		end
	end

endmodule // mgtx_cbus_rx

// file: mgtx_twist_hold.sv
`timescale 1ns/1ps
module mgtx_twist_hold #(
	parameter int unsigned TW_W = 3
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic busy_i,
	input wire logic [TW_W-1:0] req_i,
	output logic [TW_W-1:0] applied_o
);
	import mgtx_pkg::*;

	generate if (TW_W != 3) begin : g_chk
		$error("Twist code must be three bits wide.");
	end endgenerate

	// The code is frozen while a tone plays; a change lands on the next tone.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			applied_o <= '0;
		end else if (!busy_i) begin
			applied_o <= req_i;
		end
	end

endmodule // mgtx_twist_hold

// file: mgtx_ctrl.sv
// Function
// - General bit 14 set disconnects the positive line driver output.
// - General bit 13 set disconnects the inverted line driver output.
// - General bit 12 picks crystal divider: 1 is 11.0592 MHz, 0 is 12.288.
// - General bit 11 set loops transmit back into the receiver.
// - General bit 10 set disables the equalisers; clear enables them at 1200 bps.
// - General bit 9 drives the relay pin high when set, low when clear.
// - General bit 8 clear is powersave; set powers the device up.
// - A general reset clears the powerup bit, entering powersave.
// - General bit 7 set holds internal logic and transmit mode in reset.
// - General bit 6 set lets the interrupt pin pull low on a status interrupt.
// - General bits 5 to 0 mask which conditions raise the interrupt.
// - Transmit mode clears on general reset and while bit 7 is set.
// - Transmit bits 14 to 12 choose the transmit function.
// - Transmit bits 11 to 9 set level, 1.5 dB per step below 0 dB.
// - Transmit bits 7 to 5 set the upper tone group twist.
// - A twist change only takes effect from the next tone.
// - Transmit bits 4 to 3 choose synchronous or start-stop parity format.
// - Transmit bits 2 to 0 give data bits and stop bits in start-stop.
// - Transmit bits 2 to 0 choose the synchronous modulator data source.
// - A general reset clears the whole general control register.
`timescale 1ns/1ps
module mgtx_ctrl (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic csn_n_i,
	input wire logic sclk_i,
	input wire logic cmd_data_i,
	input wire logic tone_busy_i,
	input wire logic status_irq_i,
	output logic line_drive_out_pos_oe_o,
	output logic line_drive_out_inv_oe_o,
	output logic xtal_11m_sel_o,
	output logic analogue_loopback_bit_o,
	output logic tx_eq_enable_o,
	output logic eq_disable_o,
	output logic relay_output_low_o,
	output logic powerup_o,
	output logic core_reset_o,
	output logic interrupt_pin_enable_o,
	output logic irq_n_o,
	output logic irq_n_oe_o,
	output logic [5:0] irq_mask_o,
	output mgtx_pkg::mgtx_tx_mode_type tx_mode_o,
	output logic tx_dtmf_o,
	output logic [4:0] tx_atten_half_db_o,
	output logic [3:0] twist_half_db_o,
	output mgtx_pkg::mgtx_fmt_type tx_format_o,
	output logic [3:0] tx_data_bits_o,
	output logic tx_two_stop_o,
	output mgtx_pkg::mgtx_src_type tx_sync_src_o
);
	import mgtx_pkg::*;

	mgtx_wr_if wr_if ();

	logic [15:0] gen_ctrl_r;
	logic [15:0] gen_ctrl_nxt;
	logic [15:0] tx_mode_r;
	logic [15:0] tx_mode_nxt;
	logic [2:0] twist_applied;
	logic gc_write;
	logic tm_write;
	logic tm_clear;

	mgtx_cbus_rx #(
		.DATA_W(REG_W)
	) u_rx (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.csn_n_i(csn_n_i),
		.sclk_i(sclk_i),
		.cmd_data_i(cmd_data_i),
		.wr(wr_if.src)
	);

	assign gc_write = wr_if.wr_stb && (wr_if.wr_addr == ADDR_GEN_CTRL);
	assign tm_write = wr_if.wr_stb && (wr_if.wr_addr == ADDR_TX_MODE);
	assign tm_clear = wr_if.greset_stb || gen_ctrl_r[GC_RST];

	always_comb begin
		gen_ctrl_nxt = gen_ctrl_r;
		if (wr_if.greset_stb) begin
			gen_ctrl_nxt = GEN_CTRL_RST_VAL;
		end else if (gc_write) begin
			gen_ctrl_nxt = {1'b0, wr_if.wr_data[14:0]};
		end
	end

	always_comb begin
		tx_mode_nxt = tx_mode_r;
		if (tm_clear) begin
			tx_mode_nxt = TX_MODE_RST_VAL;
		end else if (tm_write) begin
			tx_mode_nxt = {1'b0, wr_if.wr_data[14:0]};
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gen_ctrl_r <= GEN_CTRL_RST_VAL;
		end else begin
			gen_ctrl_r <= gen_ctrl_nxt;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_mode_r <= TX_MODE_RST_VAL;
		end else begin
			tx_mode_r <= tx_mode_nxt;
		end
	end

	// Line driver and analogue path controls.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			line_drive_out_pos_oe_o <= 1'b1;
			line_drive_out_inv_oe_o <= 1'b1;
			xtal_11m_sel_o <= 1'b0;
			analogue_loopback_bit_o <= 1'b0;
		end else begin
			line_drive_out_pos_oe_o <= !gen_ctrl_r[GC_POS_OFF];
			line_drive_out_inv_oe_o <= !gen_ctrl_r[GC_INV_OFF];
			xtal_11m_sel_o <= gen_ctrl_r[GC_XTAL];
			analogue_loopback_bit_o <= gen_ctrl_r[GC_LOOP];
		end
	end

	// Equalisers only act in the two 1200 bps transmit modes.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			eq_disable_o <= 1'b0;
			tx_eq_enable_o <= 1'b0;
		end else begin
			eq_disable_o <= gen_ctrl_r[GC_EQ_DIS];
			tx_eq_enable_o <= !gen_ctrl_r[GC_EQ_DIS] &&
				(tx_mode_r[TM_MODE_HI:TM_MODE_LO] == TXM_V23_1200 ||
				tx_mode_r[TM_MODE_HI:TM_MODE_LO] == TXM_B202_1200);
		end
	end

	// Relay, power and internal reset stay alive in powersave.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			relay_output_low_o <= 1'b1;
			powerup_o <= 1'b0;
			core_reset_o <= 1'b1;
		end else begin
			relay_output_low_o <= !gen_ctrl_r[GC_RELAY];
			powerup_o <= gen_ctrl_r[GC_PWR];
			core_reset_o <= gen_ctrl_r[GC_RST] || wr_if.greset_stb;
		end
	end

	// The pin is open drain: it only ever pulls low.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			interrupt_pin_enable_o <= 1'b0;
			irq_n_oe_o <= 1'b0;
			irq_mask_o <= 6'h00;
		end else begin
			interrupt_pin_enable_o <= gen_ctrl_r[GC_IRQ_EN];
			irq_n_oe_o <= gen_ctrl_r[GC_IRQ_EN] && status_irq_i;
			irq_mask_o <= gen_ctrl_r[GC_MASK_HI:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_n_o <= 1'b0;
		end else begin
			irq_n_o <= 1'b0;
		end
	end

	// Transmit function and level.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_mode_o <= TXM_OFF;
			tx_dtmf_o <= 1'b0;
			tx_atten_half_db_o <= 5'h15;
		end else begin
			tx_mode_o <= mgtx_tx_mode_type'(tx_mode_r[TM_MODE_HI:TM_MODE_LO]);
			tx_dtmf_o <= tx_mode_r[TM_MODE_HI:TM_MODE_LO] == TXM_TONES;
			tx_atten_half_db_o <= 5'(3'h7 - tx_mode_r[TM_LVL_HI:TM_LVL_LO]) * 5'h03;
		end
	end

	mgtx_twist_hold #(
		.TW_W(3)
	) u_twist (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.busy_i(tone_busy_i),
		.req_i(tx_mode_r[TM_TW_HI:TM_TW_LO]),
		.applied_o(twist_applied)
	);

	// Twist is kept in half dB so the odd 0.5 dB steps stay exact.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			twist_half_db_o <= 4'h4;
		end else begin
			case (twist_applied)
				3'h0: begin
					twist_half_db_o <= 4'h4;
				end
				3'h1: begin
					twist_half_db_o <= 4'h2;
				end
				3'h2: begin
					twist_half_db_o <= 4'h3;
				end
				default: begin
					twist_half_db_o <= 4'(twist_applied) + 4'h2;
				end
			endcase
		end
	end

	// Character framing; the low three bits mean different things per format.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_format_o <= FMT_ODD;
			tx_data_bits_o <= 4'h5;
			tx_two_stop_o <= 1'b0;
		end else begin
			tx_format_o <= mgtx_fmt_type'(tx_mode_r[TM_FMT_HI:TM_FMT_LO]);
			tx_data_bits_o <= 4'h5 + 4'(tx_mode_r[TM_LEN_HI:1]);
			tx_two_stop_o <= tx_mode_r[0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_sync_src_o <= SRC_ALT;
		end else begin
			if (tx_mode_r[TM_LEN_HI]) begin
				tx_sync_src_o <= SRC_BUFFER;
			end else if (tx_mode_r[1:0] == 2'h3) begin
				tx_sync_src_o <= SRC_ONES;
			end else if (tx_mode_r[1:0] == 2'h2) begin
				tx_sync_src_o <= SRC_ZEROS;
			end else begin
				tx_sync_src_o <= SRC_ALT;
			end
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	property p_gc_reset;
		wr_if.greset_stb |=> gen_ctrl_r == 16'h0000;
	endproperty
	a_gc_reset: assert property (p_gc_reset) else $error("General reset left control bits set.");

	property p_pwr_save;
		wr_if.greset_stb |=> ##1 !powerup_o;
	endproperty
	a_pwr_save: assert property (p_pwr_save) else $error("General reset did not powersave.");

	property p_pos_off;
		$past(gen_ctrl_r[GC_POS_OFF]) |-> !line_drive_out_pos_oe_o;
	endproperty
	a_pos_off: assert property (p_pos_off) else $error("Positive output not disconnected.");

	property p_inv_off;
		line_drive_out_inv_oe_o == !$past(gen_ctrl_r[GC_INV_OFF]);
	endproperty
	a_inv_off: assert property (p_inv_off) else $error("Inverted output enable wrong.");

	property p_relay;
		relay_output_low_o == !$past(gen_ctrl_r[GC_RELAY]);
	endproperty
	a_relay: assert property (p_relay) else $error("Relay pin disagrees with its bit.");

	property p_irq_pin;
		!irq_n_o && (irq_n_oe_o == $past(gen_ctrl_r[GC_IRQ_EN] && status_irq_i));
	endproperty
	a_irq_pin: assert property (p_irq_pin) else $error("Interrupt pin drive wrong.");

	property p_rst_hold;
		gen_ctrl_r[GC_RST] |=> tx_mode_r == 16'h0000 ##1 tx_mode_o == TXM_OFF;
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("Transmit mode kept under reset.");

	property p_tm_greset;
		wr_if.greset_stb |=> tx_mode_r == 16'h0000;
	endproperty
	a_tm_greset: assert property (p_tm_greset) else $error("Transmit mode survived reset.");

	property p_whole_word;
		!$past(wr_if.wr_stb) && !$past(wr_if.greset_stb) && !$past(gen_ctrl_r[GC_RST])
			|-> $stable(tx_mode_r) && $stable(gen_ctrl_r);
	endproperty
	a_whole_word: assert property (p_whole_word) else $error("Register changed without a write.");

	property p_twist_hold;
		tone_busy_i |=> $stable(twist_applied);
	endproperty
	a_twist_hold: assert property (p_twist_hold) else $error("Twist changed during a tone.");

	property p_sync_fmt;
		$past(tx_mode_r[TM_FMT_HI:TM_FMT_LO]) == 2'h3 |-> tx_format_o == FMT_SYNC;
	endproperty
	a_sync_fmt: assert property (p_sync_fmt) else $error("Synchronous format not decoded.");

	property p_eq;
		$past(gen_ctrl_r[GC_EQ_DIS]) |-> !tx_eq_enable_o && eq_disable_o;
	endproperty
	a_eq: assert property (p_eq) else $error("Equaliser left enabled.");

	c_greset: cover property (wr_if.greset_stb);
	c_tm_write: cover property (tm_write ##1 tx_mode_r != 16'h0000);
	c_sync_buf: cover property (tx_format_o == FMT_SYNC && tx_sync_src_o == SRC_BUFFER);
	c_irq_pull: cover property (irq_n_oe_o);

endmodule // mgtx_ctrl

// file: mgtx_host_model.sv
`timescale 1ns/1ps
module mgtx_host_model (
	input wire logic clk_i,
	output logic csn_n_o,
	output logic sclk_o,
	output logic cmd_data_o
);
	initial begin
		csn_n_o = 1'b1;
		sclk_o = 1'b0;
		cmd_data_o = 1'b1;
	end

	// Data changes only while the serial clock is low, so each rise samples a settled bit.
	task automatic put_bit(input logic b, input int slow);
		@(negedge clk_i);
		cmd_data_o = b;
		@(negedge clk_i);
		sclk_o = 1'b1;
		repeat (slow + 1) @(negedge clk_i);
		sclk_o = 1'b0;
	endtask

	task automatic frame(input logic [7:0] a, input logic [15:0] d, input int nd, input int slow);
		@(negedge clk_i);
		csn_n_o = 1'b0;
		for (int i = 7; i >= 0; i--) put_bit(a[i], slow);
		for (int k = 0; k < nd; k++) put_bit(d[(15 - k) & 15], slow);
		@(negedge clk_i);
		csn_n_o = 1'b1;
		// The line is not meaningful outside a frame, so it is left at a misleading level.
		cmd_data_o = ~cmd_data_o;
		@(negedge clk_i);
	endtask
endmodule // mgtx_host_model

// file: modem_general_and_tx_mode_control_test.sv
`timescale 1ns/1ps
module modem_general_and_tx_mode_control_test;
	import mgtx_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic tone_busy_i = 1'b0;
	logic status_irq_i = 1'b0;
	logic csn_n, sclk, cmd_data;
	logic pos_oe, inv_oe, xtal, loopb, tx_eq, eq_dis, relay, pwr, core_rst, irq_en, irq_n, irq_oe;
	logic dtmf, two_stop;
	logic [5:0] mask;
	logic [4:0] atten;
	logic [3:0] twist, dbits;
	mgtx_tx_mode_type mode;
	mgtx_fmt_type fmt;
	mgtx_src_type src;
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [15:0] gc_m = 16'h0000;
	logic [15:0] tm_m = 16'h0000;
	logic [2:0] tw_m = 3'h0;
	logic [31:0] seed = 32'h0000bce3;

	always #50 clk_i = ~clk_i;

	mgtx_host_model host (.clk_i(clk_i), .csn_n_o(csn_n), .sclk_o(sclk), .cmd_data_o(cmd_data));

	mgtx_ctrl DUT (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .csn_n_i(csn_n), .sclk_i(sclk),
		.cmd_data_i(cmd_data), .tone_busy_i(tone_busy_i), .status_irq_i(status_irq_i),
		.line_drive_out_pos_oe_o(pos_oe), .line_drive_out_inv_oe_o(inv_oe),
		.xtal_11m_sel_o(xtal), .analogue_loopback_bit_o(loopb), .tx_eq_enable_o(tx_eq),
		.eq_disable_o(eq_dis), .relay_output_low_o(relay), .powerup_o(pwr),
		.core_reset_o(core_rst), .interrupt_pin_enable_o(irq_en), .irq_n_o(irq_n),
		.irq_n_oe_o(irq_oe), .irq_mask_o(mask), .tx_mode_o(mode), .tx_dtmf_o(dtmf),
		.tx_atten_half_db_o(atten), .twist_half_db_o(twist), .tx_format_o(fmt),
		.tx_data_bits_o(dbits), .tx_two_stop_o(two_stop), .tx_sync_src_o(src)
	);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic report_and_stop();
		if (n_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic check_all();
		logic [2:0] md;
		logic [2:0] lv;
		md = tm_m[14:12];
		lv = tm_m[11:9];
		if (!tone_busy_i) tw_m = tm_m[7:5];
		chk("pos_oe", !gc_m[14], pos_oe);
		chk("inv_oe", !gc_m[13], inv_oe);
		chk("xtal", gc_m[12], xtal);
		chk("loopback", gc_m[11], loopb);
		chk("eq_dis", gc_m[10], eq_dis);
		chk("tx_eq", !gc_m[10] && (md == 3'h5 || md == 3'h3), tx_eq);
		chk("relay", !gc_m[9], relay);
		chk("powerup", gc_m[8], pwr);
		chk("core_rst", gc_m[7], core_rst);
		chk("irq_en", gc_m[6], irq_en);
		chk("irq_n", 16'h0000, irq_n);
		chk("irq_oe", gc_m[6] & status_irq_i, irq_oe);
		chk("mask", gc_m[5:0], mask);
		chk("mode", md, mode);
		chk("dtmf", md == 3'h1, dtmf);
		chk("atten", 16'((7 - lv) * 3), atten);
		chk("twist", (tw_m == 0) ? 16'h4 : (tw_m == 1) ? 16'h2 : 16'(tw_m) + 16'h1 + 16'(tw_m > 2), twist);
		chk("format", tm_m[4:3], fmt);
		chk("dbits", 16'h5 + tm_m[2:1], dbits);
		chk("two_stop", tm_m[0], two_stop);
		chk("src", tm_m[2] ? 16'h0 : (tm_m[1:0] == 2'h3) ? 16'h1 : (tm_m[1:0] == 2'h2) ? 16'h2 : 16'h3, src);
	endtask

	// Only the address byte of a reset is sent; a short frame must commit nothing.
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input int nd);
		host.frame(a, d, nd, int'(rnd() % 3));
		if (a == ADDR_GEN_RESET) begin
			gc_m = 16'h0000;
			tm_m = 16'h0000;
		end else if (nd >= 16 && a == ADDR_GEN_CTRL) begin
			gc_m = d & 16'h7fff;
		end else if (nd >= 16 && a == ADDR_TX_MODE) begin
			tm_m = d & 16'h7fff;
		end
		if (gc_m[GC_RST]) tm_m = 16'h0000;
		repeat (4) @(negedge clk_i);
		check_all();
	endtask

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			report_and_stop();
		end
	end

	initial begin
		repeat (6) @(negedge clk_i);
		// While reset is applied the outputs look like the reset bit is set.
		gc_m = 16'h0080;
		check_all();
		rst_n_i = 1'b1;
		gc_m = 16'h0000;
		repeat (2) @(negedge clk_i);
		check_all();
		// reset then powerup with reset bit; the long settling hold is not modelled here.
		wr(ADDR_GEN_RESET, 16'h0000, 0);
		wr(ADDR_GEN_CTRL, 16'h0180, 16);
		wr(ADDR_TX_MODE, 16'h5e3b, 16);
		wr(ADDR_GEN_CTRL, 16'h0100, 16);
		// level falls as twist rises, so high twist never meets full level.
		for (int m = 0; m < 8; m++) begin
			wr(ADDR_TX_MODE, {1'b0, 3'(m), 3'(7 - m), 1'b0, 3'(m), 2'(m), 3'(m)}, 16);
		end
		for (int i = 0; i < 16; i++) begin
			logic [15:0] g;
			logic [15:0] t;
			g = 16'(rnd());
			g[GC_RST] = (i % 4 == 0);
			// loopback stays off while the receive side has no matching mode.
			g[GC_LOOP] = 1'b0;
			t = 16'(rnd());
			if (t[7:5] >= 3'h3 && t[11:9] == 3'h7) t[9] = 1'b0;
			wr(ADDR_GEN_CTRL, g, 16);
			wr(ADDR_TX_MODE, t, 16);
		end
		wr(ADDR_GEN_CTRL, 16'h0100, 16);
		wr(ADDR_TX_MODE, 16'h3a6a, 16);
		wr(ADDR_TX_MODE, 16'h1234, 15);
		// Receive side gets the same modem type before loopback is switched on.
		wr(8'he2, 16'h3e00, 16);
		wr(ADDR_GEN_CTRL, 16'h4b5c, 20);
		wr(ADDR_GEN_RESET, 16'h0000, 0);
		wr(ADDR_TX_MODE, 16'h1e00, 16);
		tone_busy_i = 1'b1;
		wr(ADDR_TX_MODE, 16'h1cc0, 16);
		tone_busy_i = 1'b0;
		repeat (3) @(negedge clk_i);
		check_all();
		wr(ADDR_GEN_CTRL, 16'h0140, 16);
		for (int i = 0; i < 40; i++) begin
			if (i == 20) wr(ADDR_GEN_CTRL, 16'h0100, 16);
			status_irq_i = 1'(rnd());
			@(negedge clk_i);
			chk("irq_oe", gc_m[GC_IRQ_EN] & status_irq_i, irq_oe);
		end
		report_and_stop();
	end
endmodule // modem_general_and_tx_mode_control_test
